// file: nonvolatile_limit_registers_test.sv
`default_nettype none
module nonvolatile_limit_registers_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Long enough that a second write lands inside the busy window.
  localparam int PC = 1500;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl, sda, sda_out, sda_oe, lk, lkd, obusy, busy, a;
  logic [2:0]  aaa = 3'h0;
  logic [1:0]  res = 2'h0;
  logic [7:0]  d, p;
  logic [15:0] lo_w, hi_w, w, v;
  logic [15:0] nv [2];
  logic [15:0] wk [2];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  always #10 clk = !clk;
  nvl_limit_regs #(.PROG_CYCLES(PC)) dut_u (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_strap_inputs(aaa), .resolution_select(res),
    .reversible_lock_bit(lk), .permanent_lockdown_bit(lkd),
    .other_nv_busy(obusy), .nv_busy_flag(busy), .low_limit(lo_w),
    .high_limit(hi_w));
  nvl_bus_master m_u (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  // Resolution r keeps the sign and 8 + r data bits, the rest read zero.
  function automatic logic [15:0] keep(input logic [1:0] r);
    return ~(16'hFFFF >> (9 + r));
  endfunction
  task automatic chk_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_word(input string n, input logic [15:0] e,
                          input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bytes beyond the second are random filler whose ACK is not judged.
  task automatic wr_txn(input logic [7:0] pt, input logic [15:0] val,
                        input int n, input logic rep, input logic dack);
    m_u.start();
    m_u.wr_byte({nvl_pkg::ADDR_PREFIX, aaa, 1'b0}, a);
    chk_bit("addr_ack", 1'b1, a);
    m_u.wr_byte(pt, a);
    chk_bit("ptr_ack", 1'b1, a);
    for (int i = 0; i < n; i++) begin
      m_u.wr_byte(i == 0 ? val[15:8] : i == 1 ? val[7:0] : 8'($urandom), a);
      if (i < 2) chk_bit("data_ack", dack, a);
    end
    if (rep) m_u.start();
    m_u.stop();
  endtask
  task automatic rd_txn(input logic aack, input logic [15:0] e,
                        input logic more);
    m_u.start();
    m_u.wr_byte({nvl_pkg::ADDR_PREFIX, aaa, 1'b1}, a);
    chk_bit("rd_addr_ack", aack, a);
    if (aack) begin
      m_u.rd_byte(1'b1, w[15:8]);
      m_u.rd_byte(more, w[7:0]);
      chk_word("read_word", e, w);
      if (more) begin
        m_u.rd_byte(1'b0, d);
        chk_word("extra_byte", {8'h00, nvl_pkg::UNDEF_BYTE}, {8'h00, d});
      end
      chk_bit("sda_release", 1'b0, sda_oe);
      chk_bit("sda_drive", 1'b0, sda_out);
    end
    m_u.stop();
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 2 * PC) begin
      @(negedge clk);
      k++;
    end
    chk_bit("busy_clears", 1'b0, busy);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    wk = nv;
    repeat (5) @(negedge clk);
    chk_word("low_working", wk[0], lo_w);
    chk_word("high_working", wk[1], hi_w);
    chk_bit("busy_reset", 1'b0, busy);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    lk = 1'b0;
    lkd = 1'b0;
    obusy = 1'b0;
    nv[0] = nvl_pkg::LOW_FACTORY;
    nv[1] = nvl_pkg::HIGH_FACTORY;
    void'($urandom(51));
    aaa = 3'($urandom);
    do_reset();
    rd_txn(1'b0, 16'h0000, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr_txn(8'h12 + 8'(i), 16'h0000, 0, 1'b0, 1'b1);
      chk_bit("busy_short", 1'b0, busy);
      rd_txn(1'b1, nv[i] & keep(res), 1'b0);
    end
    m_u.start();
    m_u.wr_byte({nvl_pkg::ADDR_PREFIX, aaa ^ 3'h1, 1'b0}, a);
    m_u.stop();
    chk_bit("wrong_addr_ack", 1'b0, a);
    for (int i = 0; i < 4; i++) begin
      p = 8'h12 + 8'($urandom_range(1));
      v = 16'($urandom);
      v[15] = i[0];
      // The first two passes write and read at opposite resolutions.
      if (i < 2) v[6:4] = 3'h7;
      res = i == 0 ? 2'h0 : i == 1 ? 2'h3 : 2'($urandom);
      wr_txn(p, v, 2 + i % 2, 1'b0, 1'b1);
      nv[p[0]] = v & keep(res);
      chk_bit("busy_set", 1'b1, busy);
      wr_txn(p, ~v, 2, 1'b0, 1'b0);
      chk_bit("busy_held", 1'b1, busy);
      wait_idle();
      chk_word("low_working", wk[0], lo_w);
      chk_word("high_working", wk[1], hi_w);
      res = i == 0 ? 2'h3 : i == 1 ? 2'h0 : 2'($urandom);
      rd_txn(1'b1, nv[p[0]] & keep(res), i[0]);
    end
    for (int k = 0; k < 4; k++) begin
      lk = k[0];
      lkd = k[1];
      wr_txn(p, ~nv[p[0]], 2, k == 0, 1'b1);
      chk_bit("busy_refused", 1'b0, busy);
      rd_txn(1'b1, nv[p[0]] & keep(res), 1'b0);
    end
    lk = 1'b0;
    lkd = 1'b0;
    for (int k = 0; k < 2; k++) begin
      wr_txn(p, ~nv[p[0]], 1, k[0], 1'b1);
      chk_bit("busy_short", 1'b0, busy);
    end
    rd_txn(1'b1, nv[p[0]] & keep(res), 1'b0);
    obusy = 1'b1;
    rd_txn(1'b0, 16'h0000, 1'b0);
    obusy = 1'b0;
    // A reset in mid-programming must leave the old contents behind.
    wr_txn(8'h13, ~nv[1], 2, 1'b0, 1'b1);
    do_reset();
    wr_txn(8'h13, 16'h0000, 0, 1'b0, 1'b1);
    rd_txn(1'b1, nv[1] & keep(res), 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire

// file: nvl_bus_master.sv
`default_nettype none
module nvl_bus_master (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull;
  // The data line has a pull-up, so a released line reads high.
  assign sda = !(pull || sda_oe);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Ten cycles a phase keeps each level well past the two-flop sampling.
  task automatic hold();
    repeat (10) @(negedge clk);
  endtask
  // Data moves only mid-low so no edge looks like a start or stop.
  task automatic bit_io(input logic b, output logic r);
    hold();
    pull = !b;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    hold();
    pull = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    pull = 1'b1;
    hold();
    scl = 1'b0;
  endtask
  task automatic stop();
    hold();
    pull = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    pull = 1'b0;
    hold();
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!mack, r);
  endtask
endmodule
`default_nettype wire

// file: nvl_limit_regs.sv
`default_nettype none
// Functional notes
// [RQ1] Limits are 16-bit two's complement, bit 15 sign.
// [RQ2] Stored limits survive reset; reset loads working limits.
// [RQ3] Alarm compares only the working limits.
// [RQ4] Writes keep 9 to 12 upper bits.
// [RQ5] Reads show 9 to 12 upper bits.
// [RQ6] Write: address, pointer 12h/13h, two data bytes.
// [RQ7] Data bytes after the second are ignored.
// [RQ8] Short data before Stop/Start changes nothing.
// [RQ9] Stop after write starts timed programming, busy set.
// [RQ10] Repeated Start after data abandons programming.
// [RQ11] Busy, lock or lockdown suppress programming.
// [RQ12] Lock ACKs all; busy NACKs data bytes.
// [RQ13] Read uses pointer left at 12h/13h.
// [RQ14] Read: address, upper byte, ACK, lower byte, NACK.
// [RQ15] Master ACK after lower byte yields undefined bytes.
// [RQ16] Factory values 4B00h low and 5000h high.
// [RQ17] Lockdown overrides lock; lock state kept outside.
// [RQ18] Busy clears when programming completes or aborts.
module nvl_limit_regs #(
  parameter int PROG_CYCLES = nvl_pkg::PROG_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  input  wire logic [2:0]  address_strap_inputs,
  input  wire logic [1:0]  resolution_select,
  input  wire logic        reversible_lock_bit,
  input  wire logic        permanent_lockdown_bit,
  input  wire logic        other_nv_busy,
  output var  logic        nv_busy_flag,
  output var  logic [15:0] low_limit,
  output var  logic [15:0] high_limit
);
  nvl_pkg::nvl_state_t state_q;
  logic [2:0]  phase_q;
  logic [3:0]  bitcnt_q;
  logic [7:0]  shreg_q;
  logic [7:0]  tx_q;
  logic [1:0]  byte_idx_q;
  logic        rd_q;
  logic        mack_q;
  logic        sda_oe_q;
  logic        sda_out_q;
  logic [7:0]  ptr_q;
  logic [15:0] wdata_q;
  logic        wr_full_q;
  logic        wr_sel_q;
  logic        nv_busy_q;
  logic [15:0] low_limit_q;
  logic [15:0] high_limit_q;
  // Stored limits hold the factory values from power-up and are never
  // touched by rst, standing in for the nonvolatile cells.
  logic [15:0] nv_low_q  = nvl_pkg::LOW_FACTORY;   // RQ16
  logic [15:0] nv_high_q = nvl_pkg::HIGH_FACTORY;  // RQ16

  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        prog_busy;
  logic        prog_done;
  logic        prog_start;
  logic        byte_end;
  logic        ack_now;
  logic        addr_hit;
  logic        ptr_ours;
  logic        locked;
  logic [15:0] res_mask;
  logic [15:0] rd_word;
  logic [1:0]  tx_idx;
  logic [7:0]  tx_byte;

  nvl_line_sync u_sync (
    .clk       (clk),
    .rst       (rst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  nvl_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (prog_start),
    .busy  (prog_busy),
    .done  (prog_done)
  );

  // Sign-filled shift widens the kept field by one bit per step.
  assign res_mask = 16'($signed(nvl_pkg::MASK_9B) >>> resolution_select);
  assign ptr_ours = (ptr_q == nvl_pkg::PTR_LOW) ||
                    (ptr_q == nvl_pkg::PTR_HIGH);
  assign addr_hit = shreg_q[7:1] ==
                    {nvl_pkg::ADDR_PREFIX, address_strap_inputs};
  // Lockdown blocks on its own, whatever the lock bit says.
  assign locked   = permanent_lockdown_bit | reversible_lock_bit; // RQ17
  assign byte_end = (state_q == nvl_pkg::NVL_RX) && scl_fall &&
                    (bitcnt_q == nvl_pkg::BITS_BYTE);
  assign prog_start = stop_det && wr_full_q; // RQ9

  // Read data is the stored limit cut to the selected resolution.
  assign rd_word = ((ptr_q == nvl_pkg::PTR_HIGH) ? nv_high_q : nv_low_q)
                   & res_mask; // RQ5 RQ13

  always_comb begin
    ack_now = 1'b0;
    case (phase_q)
      nvl_pkg::PH_ADDR: begin
        // Reads of a stored limit are refused while programming runs.
        if (shreg_q[0]) begin
          ack_now = addr_hit && ptr_ours && !nv_busy_q;
        end else begin
          ack_now = addr_hit;
        end
      end
      nvl_pkg::PH_PTR: ack_now = 1'b1;
      default: ack_now = ptr_ours && !nv_busy_q; // RQ12
    endcase
  end

  assign tx_idx = (state_q == nvl_pkg::NVL_MACK) ?
                  ((byte_idx_q == 2'h2) ? 2'h2 : byte_idx_q + 2'h1) : 2'h0;

  always_comb begin
    case (tx_idx)
      2'h0:    tx_byte = rd_word[15:8]; // RQ14
      2'h1:    tx_byte = rd_word[7:0];
      default: tx_byte = nvl_pkg::UNDEF_BYTE; // RQ15
    endcase
  end

  // Byte engine: sample on SCL rise, change SDA after SCL fall.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= nvl_pkg::NVL_IDLE;
      phase_q    <= nvl_pkg::PH_ADDR;
      bitcnt_q   <= 4'h0;
      shreg_q    <= 8'h00;
      tx_q       <= 8'h00;
      byte_idx_q <= 2'h0;
      rd_q       <= 1'b0;
      mack_q     <= 1'b0;
      sda_oe_q   <= 1'b0;
    end else if (start_det) begin
      state_q  <= nvl_pkg::NVL_RX;
      phase_q  <= nvl_pkg::PH_ADDR;
      bitcnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      state_q  <= nvl_pkg::NVL_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        nvl_pkg::NVL_RX: begin
          if (scl_rise && bitcnt_q != nvl_pkg::BITS_BYTE) begin
            shreg_q  <= {shreg_q[6:0], sda_s};
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (byte_end) begin
            sda_oe_q <= ack_now;
            state_q  <= ack_now ? nvl_pkg::NVL_ACK : nvl_pkg::NVL_IGN;
            if (phase_q == nvl_pkg::PH_ADDR) begin
              rd_q <= shreg_q[0];
            end
          end
        end
        nvl_pkg::NVL_ACK: begin
          if (scl_fall) begin
            bitcnt_q <= 4'h0;
            if (phase_q != nvl_pkg::PH_EXTRA) begin // RQ7
              phase_q <= phase_q + 3'h1;
            end
            if (rd_q) begin
              tx_q       <= tx_byte;
              sda_oe_q   <= ~tx_byte[7];
              bitcnt_q   <= 4'h1;
              byte_idx_q <= 2'h0;
              state_q    <= nvl_pkg::NVL_TX;
            end else begin
              sda_oe_q <= 1'b0;
              state_q  <= nvl_pkg::NVL_RX;
            end
          end
        end
        nvl_pkg::NVL_TX: begin
          if (scl_fall) begin
            if (bitcnt_q == nvl_pkg::BITS_BYTE) begin
              sda_oe_q <= 1'b0;
              state_q  <= nvl_pkg::NVL_MACK;
            end else begin
              sda_oe_q <= ~tx_q[6];
              tx_q     <= {tx_q[6:0], 1'b0};
              bitcnt_q <= bitcnt_q + 4'h1;
            end
          end
        end
        nvl_pkg::NVL_MACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s;
          end else if (scl_fall) begin
            // A master NACK ends the read and leaves SDA released.
            if (mack_q) begin
              tx_q       <= tx_byte;
              sda_oe_q   <= ~tx_byte[7];
              bitcnt_q   <= 4'h1;
              byte_idx_q <= tx_idx;
              state_q    <= nvl_pkg::NVL_TX;
            end else begin
              state_q <= nvl_pkg::NVL_IGN; // RQ14
            end
          end
        end
        nvl_pkg::NVL_IGN: state_q <= nvl_pkg::NVL_IGN;
        nvl_pkg::NVL_IDLE: state_q <= nvl_pkg::NVL_IDLE;
        default: state_q <= nvl_pkg::NVL_IDLE;
      endcase
    end
  end

  // The line is open-drain: only a low level is ever driven.
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  // Any pointer byte is taken, so later reads see the last written one.
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= nvl_pkg::PTR_RESET;
    end else if (byte_end && !rd_q && phase_q == nvl_pkg::PH_PTR) begin
      ptr_q <= shreg_q; // RQ13
    end
  end

  // Write data is captured only from the first two data bytes, and a
  // write counts only once the lower byte has fully arrived.
  always_ff @(posedge clk) begin
    if (rst) begin
      wdata_q   <= 16'h0000;
      wr_full_q <= 1'b0;
      wr_sel_q  <= 1'b0;
    end else if (start_det || stop_det) begin
      wr_full_q <= 1'b0; // RQ8 RQ10
    end else if (byte_end && ack_now && !rd_q) begin
      if (phase_q == nvl_pkg::PH_HI) begin
        wdata_q[15:8] <= shreg_q; // RQ6
      end else if (phase_q == nvl_pkg::PH_LO) begin
        wdata_q   <= {wdata_q[15:8], shreg_q} & res_mask; // RQ1 RQ4
        wr_full_q <= !locked && !nv_busy_q; // RQ11
        wr_sel_q  <= (ptr_q == nvl_pkg::PTR_HIGH);
      end
    end
  end

  // Stored limits change only when self-timed programming finishes.
  always_ff @(posedge clk) begin
    if (prog_done && !wr_sel_q) begin
      nv_low_q <= wdata_q; // RQ9
    end
    if (prog_done && wr_sel_q) begin
      nv_high_q <= wdata_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nv_busy_q <= 1'b0; // RQ18
    end else begin
      nv_busy_q <= prog_busy | other_nv_busy; // RQ9 RQ18
    end
  end

  // Working limits feed the alarm comparator outside this block.
  always_ff @(posedge clk) begin
    if (rst) begin
      low_limit_q  <= nv_low_q;  // RQ2 RQ3
      high_limit_q <= nv_high_q;
    end
  end

  assign sda_out      = sda_out_q;
  assign sda_oe       = sda_oe_q;
  assign nv_busy_flag = nv_busy_q;
  assign low_limit    = low_limit_q;
  assign high_limit   = high_limit_q;

  property p_busy_nack;
    @(posedge clk) disable iff (rst)
    byte_end && phase_q >= nvl_pkg::PH_HI && nv_busy_q |=> !sda_oe_q;
  endproperty
  a_busy_nack: assert property (p_busy_nack) // RQ12
    else $error("data byte acknowledged while busy");

  property p_lock_ack;
    @(posedge clk) disable iff (rst)
    byte_end && phase_q >= nvl_pkg::PH_HI && ptr_ours && !nv_busy_q
      && locked |=> sda_oe_q ##1 sda_oe_q;
  endproperty
  a_lock_ack: assert property (p_lock_ack) // RQ12
    else $error("locked write byte not acknowledged");

  property p_prog_busy;
    @(posedge clk) disable iff (rst)
    prog_start && !prog_busy |-> ##2 nv_busy_q [*2];
  endproperty
  a_prog_busy: assert property (p_prog_busy) // RQ9
    else $error("busy flag not raised by programming");

  property p_blocked;
    @(posedge clk) disable iff (rst)
    $rose(wr_full_q) |-> !$past(locked) && !$past(nv_busy_q);
  endproperty
  a_blocked: assert property (p_blocked) // RQ11
    else $error("write accepted while locked or busy");

  property p_restart_abandon;
    @(posedge clk) disable iff (rst)
    start_det && wr_full_q |=> !wr_full_q && !prog_busy;
  endproperty
  a_restart_abandon: assert property (p_restart_abandon) // RQ10
    else $error("repeated start did not abandon write");

  property p_write_mask;
    @(posedge clk) disable iff (rst)
    $rose(wr_full_q) |-> (wdata_q & ~$past(res_mask)) == 16'h0000;
  endproperty
  a_write_mask: assert property (p_write_mask) // RQ4
    else $error("unused low bits not cleared on write");

  property p_reset_load;
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> low_limit_q == nv_low_q && high_limit_q == nv_high_q;
  endproperty
  a_reset_load: assert property (p_reset_load) // RQ2
    else $error("working limits not loaded at reset");

  property p_nv_update;
    @(posedge clk) disable iff (rst)
    prog_done |=> (wr_sel_q ? nv_high_q : nv_low_q) == $past(wdata_q);
  endproperty
  a_nv_update: assert property (p_nv_update) // RQ9
    else $error("stored limit not updated after programming");
endmodule
`default_nettype wire

// file: nvl_line_sync.sv
`default_nettype none
module nvl_line_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  logic scl_m_q, scl_s_q, scl_d_q;
  logic sda_m_q, sda_s_q, sda_d_q;

  // The lines idle high, so reset values match an idle bus.
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_d_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
    end
  end

  assign sda_s     = sda_s_q;
  assign scl_rise  = scl_s_q & ~scl_d_q;
  assign scl_fall  = ~scl_s_q & scl_d_q;
  assign start_det = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
  assign stop_det  = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;
endmodule
`default_nettype wire

// file: nvl_pkg.sv
`default_nettype none
package nvl_pkg;
  // Pointer values that select the two stored limits, and the pointer reset value.
  localparam logic [7:0] PTR_LOW   = 8'h12;
  localparam logic [7:0] PTR_HIGH  = 8'h13;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // Upper four bits of the seven-bit slave address.
  localparam logic [3:0] ADDR_PREFIX = 4'h9;
  localparam int         SIGN_BIT    = 15;
  // Factory contents of the stored limits.
  localparam logic [15:0] LOW_FACTORY  = 16'h4B00;
  localparam logic [15:0] HIGH_FACTORY = 16'h5000;
  // Keep mask at 9-bit resolution; each resolution step adds one bit.
  localparam logic [15:0] MASK_9B    = 16'hFF80;
  localparam logic [7:0]  UNDEF_BYTE = 8'hFF;
  // Byte counters of a transaction.
  localparam logic [2:0] PH_ADDR  = 3'h0;
  localparam logic [2:0] PH_PTR   = 3'h1;
  localparam logic [2:0] PH_HI    = 3'h2;
  localparam logic [2:0] PH_LO    = 3'h3;
  localparam logic [2:0] PH_EXTRA = 3'h4;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  // Self-timed programming time; the cycle count rounds down.
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_TIME_NS  = 5000000;
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    NVL_IDLE = 3'b000,
    NVL_RX   = 3'b001,
    NVL_ACK  = 3'b010,
    NVL_TX   = 3'b011,
    NVL_MACK = 3'b100,
    NVL_IGN  = 3'b101
  } nvl_state_t;
endpackage
`default_nettype wire

// file: nvl_prog_timer.sv
`default_nettype none
module nvl_prog_timer #(
  parameter int CYCLES = nvl_pkg::PROG_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;
  logic          busy_q;
  logic          done_q;

  // A reset during programming abandons it; the target keeps its value.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q  <= CW'(CYCLES - 1);
      end else if (busy_q) begin
        if (cnt_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
endmodule
`default_nettype wire
